// File: rtl/low_power_halt_control.sv
// Contract
// - reset low then power-save low stops oscillator
// - power-save high, then reset release restarts at zero
// - step low then power-save low stops oscillator
// - power-save high, then step high resumes state
// - opcode 01 hex enters idle
// - idle keeps oscillator, gates core clocks, holds state
// - reset ends idle, restarts at address zero
// - interrupt wake enabled: one instruction, then service
// - interrupt wake disabled: continue after idle instruction
// - ports and test pin hold values in idle
// - power-down ignores reset, step; pull-ups off
// - any reset disables external interrupt
// - step low waits after current instruction
module low_power_halt_control
  import low_power_halt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire ctrl_pins_t pins_n,
  input wire logic insn_valid,
  input wire logic [7:0] insn_opcode,
  input wire logic insn_done,
  input wire logic irq_enable_cmd,
  input wire logic irq_disable_cmd,
  output power_ctrl_t pwr_ctrl,
  output logic [11:0] restart_vector,
  output logic irq_enabled_state,
  output logic irq_take,
  output logic step_wait,
  output pwr_state_t state
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  ctrl_pins_t pins_s;

  level_sync #(
    .WIDTH(CTRL_PINS_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pins_n),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------------
  // previous pin levels, for ordering checks
  // ----------------------------------------------------------------------
  logic reset_low_prev_ff;
  logic step_low_prev_ff;
  logic nxt_reset_low_prev;
  logic nxt_step_low_prev;

  always_comb begin
    nxt_reset_low_prev = ~pins_s.reset_n;
    nxt_step_low_prev = ~pins_s.single_step_n;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_low_prev_ff <= 1'b0;
      step_low_prev_ff <= 1'b0;
    end else begin
      reset_low_prev_ff <= nxt_reset_low_prev;
      step_low_prev_ff <= nxt_step_low_prev;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  pwr_state_t state_ff;
  pwr_state_t nxt_state;
  logic irq_enabled_ff;
  logic halt_fetch;
  logic ps_low;
  logic rst_low;
  logic ss_low;
  logic int_low;

  always_comb begin
    halt_fetch = insn_valid && (insn_opcode == HALT_OPCODE);
    ps_low = ~pins_s.power_save_n;
    rst_low = ~pins_s.reset_n;
    ss_low = ~pins_s.single_step_n;
    int_low = ~pins_s.int_n;
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (ps_low && reset_low_prev_ff) begin
          nxt_state = ST_PD_RAM;
        end else if (!rst_low) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_low) begin
          nxt_state = ST_RESET;
        end else if (halt_fetch) begin
          nxt_state = ST_IDLE;
        end else if (ss_low && insn_done) begin
          nxt_state = ST_STEP;
        end
      end
      ST_STEP: begin
        if (rst_low) begin
          nxt_state = ST_RESET;
        end else if (ps_low && step_low_prev_ff) begin
          nxt_state = ST_PD_ALL;
        end else if (!ss_low) begin
          nxt_state = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (rst_low) begin
          nxt_state = ST_RESET;
        end else if (int_low && irq_enabled_ff) begin
          nxt_state = ST_ONE_INSN;
        end else if (int_low) begin
          nxt_state = ST_RUN;
        end
      end
      ST_ONE_INSN: begin
        if (rst_low) begin
          nxt_state = ST_RESET;
        end else if (insn_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_PD_RAM: begin
        if (!ps_low) begin
          nxt_state = ST_RESET;
        end
      end
      ST_PD_ALL: begin
        if (!ps_low) begin
          nxt_state = ST_STEP;
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt enable and service request
  // ----------------------------------------------------------------------
  logic irq_take_ff;
  logic nxt_irq_enabled;
  logic nxt_irq_take;

  always_comb begin
    nxt_irq_enabled = irq_enabled_ff;
    if (nxt_state == ST_RESET) begin
      nxt_irq_enabled = 1'b0;
    end else if (irq_enable_cmd) begin
      nxt_irq_enabled = 1'b1;
    end else if (irq_disable_cmd) begin
      nxt_irq_enabled = 1'b0;
    end
    nxt_irq_take = (state_ff == ST_ONE_INSN) && insn_done && !rst_low;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_enabled_ff <= 1'b0;
      irq_take_ff <= 1'b0;
    end else begin
      irq_enabled_ff <= nxt_irq_enabled;
      irq_take_ff <= nxt_irq_take;
    end
  end

  // ----------------------------------------------------------------------
  // power and clock controls
  // ----------------------------------------------------------------------
  power_ctrl_t pwr_ctrl_ff;
  power_ctrl_t nxt_pwr_ctrl;
  logic step_wait_ff;
  logic nxt_step_wait;
  logic [11:0] restart_vector_ff;
  logic [11:0] nxt_restart_vector;

  always_comb begin
    nxt_pwr_ctrl.osc_run = 1'b1;
    nxt_pwr_ctrl.core_clk_en = 1'b1;
    nxt_pwr_ctrl.core_reset = 1'b0;
    nxt_pwr_ctrl.pin_hold = 1'b0;
    nxt_pwr_ctrl.pullup_en = 1'b1;
    nxt_step_wait = 1'b0;
    nxt_restart_vector = RESET_VECTOR;
    case (nxt_state)
      ST_RESET: begin
        nxt_pwr_ctrl.core_reset = 1'b1;
      end
      ST_STEP: begin
        nxt_pwr_ctrl.core_clk_en = 1'b0;
        nxt_step_wait = 1'b1;
      end
      ST_IDLE: begin
        nxt_pwr_ctrl.core_clk_en = 1'b0;
        nxt_pwr_ctrl.pin_hold = 1'b1;
      end
      ST_PD_RAM: begin
        nxt_pwr_ctrl.osc_run = 1'b0;
        nxt_pwr_ctrl.core_clk_en = 1'b0;
        nxt_pwr_ctrl.core_reset = 1'b1;
        nxt_pwr_ctrl.pullup_en = 1'b0;
      end
      ST_PD_ALL: begin
        nxt_pwr_ctrl.osc_run = 1'b0;
        nxt_pwr_ctrl.core_clk_en = 1'b0;
        nxt_pwr_ctrl.pullup_en = 1'b0;
        nxt_step_wait = 1'b1;
      end
      default: begin
        nxt_pwr_ctrl.osc_run = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_ctrl_ff <= '{osc_run: 1'b1, core_clk_en: 1'b1, core_reset: 1'b1,
                       pin_hold: 1'b0, pullup_en: 1'b1};
      step_wait_ff <= 1'b0;
      restart_vector_ff <= RESET_VECTOR;
    end else begin
      pwr_ctrl_ff <= nxt_pwr_ctrl;
      step_wait_ff <= nxt_step_wait;
      restart_vector_ff <= nxt_restart_vector;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pwr_ctrl = pwr_ctrl_ff;
  assign restart_vector = restart_vector_ff;
  assign irq_enabled_state = irq_enabled_ff;
  assign irq_take = irq_take_ff;
  assign step_wait = step_wait_ff;
  assign state = state_ff;

endmodule : low_power_halt_control

// File: inc/low_power_halt_pkg.sv
package low_power_halt_pkg;

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  localparam logic [7:0] HALT_OPCODE = 8'h01;
  localparam logic [11:0] RESET_VECTOR = 12'h000;

  // ----------------------------------------------------------------------
  // timing of the outside party, in its own units and in cycles
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SETUP_HOLD_MS = 10;
  localparam int RELEASE_HOLD_US = 10;
  localparam longint SETUP_HOLD_PS = longint'(SETUP_HOLD_MS) * 64'd1000000000;
  localparam int SETUP_HOLD_CYCLES = int'((SETUP_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELEASE_HOLD_CYCLES = (RELEASE_HOLD_US * 1000000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam logic SYNC_RESET_LEVEL = 1'b1;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic reset_n;
    logic power_save_n;
    logic single_step_n;
    logic int_n;
  } ctrl_pins_t;

  localparam int CTRL_PINS_W = $bits(ctrl_pins_t);

  typedef struct packed {
    logic osc_run;
    logic core_clk_en;
    logic core_reset;
    logic pin_hold;
    logic pullup_en;
  } power_ctrl_t;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_RESET    = 8'b0000_0001,
    ST_RUN      = 8'b0000_0010,
    ST_STEP     = 8'b0000_0100,
    ST_IDLE     = 8'b0000_1000,
    ST_ONE_INSN = 8'b0001_0000,
    ST_PD_RAM   = 8'b0010_0000,
    ST_PD_ALL   = 8'b0100_0000,
    ST_SPARE    = 8'b1000_0000
  } pwr_state_t;

endpackage : low_power_halt_pkg

// File: rtl/level_sync.sv
module level_sync
  import low_power_halt_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // two flop chain, first stage read only by second
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= {WIDTH{SYNC_RESET_LEVEL}};
      sync_ff <= {WIDTH{SYNC_RESET_LEVEL}};
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : level_sync

// File: sim/low_power_halt_sva.sv
module low_power_halt_sva
  import low_power_halt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire ctrl_pins_t pins_n,
  input wire logic insn_valid,
  input wire logic [7:0] insn_opcode,
  input wire logic insn_done,
  input wire power_ctrl_t pwr_ctrl,
  input wire logic [11:0] restart_vector,
  input wire logic irq_enabled_state,
  input wire logic irq_take,
  input wire logic step_wait,
  input wire pwr_state_t state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  pd_quiet_a: assert property ((state == ST_PD_RAM || state == ST_PD_ALL) |->
    !pwr_ctrl.osc_run && !pwr_ctrl.pullup_en) else $error("oscillator or pull-up on");
  idle_entry_a: assert property ((pins_n == 4'hF) [*3] ##0 (state == ST_RUN &&
    insn_valid && insn_opcode == HALT_OPCODE) |=> state == ST_IDLE && pwr_ctrl.pin_hold)
    else $error("halt opcode not taken");
  idle_clock_a: assert property (state == ST_IDLE |->
    pwr_ctrl.osc_run && !pwr_ctrl.core_clk_en) else $error("idle clocks wrong");
  idle_reset_a: assert property (state == ST_IDLE && $fell(pins_n.reset_n) |->
    ##[1:3] state == ST_RESET) else $error("reset did not end idle");
  reset_state_a: assert property (state == ST_RESET |-> pwr_ctrl.core_reset &&
    !irq_enabled_state && restart_vector == RESET_VECTOR) else $error("reset outputs wrong");
  take_cause_a: assert property (irq_take |-> $past(state) == ST_ONE_INSN &&
    $past(insn_done) && state == ST_RUN ##1 !irq_take) else $error("service pulse wrong");
  one_insn_a: assert property (state == ST_IDLE ##1 state == ST_ONE_INSN |->
    irq_enabled_state) else $error("one instruction while disabled");
  wake_plain_a: assert property (state == ST_IDLE ##1 state == ST_RUN |->
    !irq_enabled_state && !irq_take) else $error("plain wake while enabled");
  ps_ignored_a: assert property ((state == ST_PD_RAM || state == ST_PD_ALL) &&
    $past(state) != state |-> !$past(pins_n.power_save_n, 3) &&
    (!$past(pins_n.reset_n, 4) || !$past(pins_n.single_step_n, 4)))
    else $error("power save not refused");
  step_wait_a: assert property (state == ST_STEP |-> step_wait)
    else $error("step wait low");
  pd_hold_a: assert property ((!pins_n.power_save_n) [*3] ##0 (state == ST_PD_RAM ||
    state == ST_PD_ALL) |=> $stable(state)) else $error("power-down left");
endmodule : low_power_halt_sva

bind low_power_halt_control low_power_halt_sva chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .pins_n(pins_n),
  .insn_valid(insn_valid),
  .insn_opcode(insn_opcode),
  .insn_done(insn_done),
  .pwr_ctrl(pwr_ctrl),
  .restart_vector(restart_vector),
  .irq_enabled_state(irq_enabled_state),
  .irq_take(irq_take),
  .step_wait(step_wait),
  .state(state)
);

// File: sim/ext_pins_model.sv
module ext_pins_model
  import low_power_halt_pkg::*;
#(
  parameter int HOLD_CYC = 6
) (
  input wire logic ref_clk,
  output ctrl_pins_t pins_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_n = 4'hF;
  // each change waits the hold gap after the previous one
  task automatic put(input ctrl_pins_t v);
    repeat (HOLD_CYC) @(posedge ref_clk);
    pins_n <= v;
  endtask : put
endmodule : ext_pins_model

// File: sim/tb_low_power_halt_control.sv
module tb_low_power_halt_control
  import low_power_halt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic insn_valid = 1'h0;
  logic [7:0] insn_opcode = 8'h00;
  logic insn_done = 1'h0;
  logic irq_enable_cmd = 1'h0;
  logic irq_disable_cmd = 1'h0;
  ctrl_pins_t pins_n;
  power_ctrl_t pwr_ctrl;
  logic [11:0] restart_vector;
  logic irq_enabled_state;
  logic irq_take;
  logic step_wait;
  pwr_state_t state;
  int n_errors = 0;
  int cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  ext_pins_model pm (
    .ref_clk(ref_clk),
    .pins_n(pins_n)
  );
  low_power_halt_control dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins_n(pins_n),
    .insn_valid(insn_valid),
    .insn_opcode(insn_opcode),
    .insn_done(insn_done),
    .irq_enable_cmd(irq_enable_cmd),
    .irq_disable_cmd(irq_disable_cmd),
    .pwr_ctrl(pwr_ctrl),
    .restart_vector(restart_vector),
    .irq_enabled_state(irq_enabled_state),
    .irq_take(irq_take),
    .step_wait(step_wait),
    .state(state)
  );
  // ----
  // helpers
  // ----
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic pulse(input logic [3:0] sel, input logic [7:0] code);
    @(posedge ref_clk);
    {insn_valid, insn_done, irq_enable_cmd, irq_disable_cmd} <= sel;
    insn_opcode <= code;
    @(posedge ref_clk);
    {insn_valid, insn_done, irq_enable_cmd, irq_disable_cmd} <= 4'h0;
    #1;
  endtask : pulse
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // ----
  // scenarios
  // ----
  task automatic t_halt(input logic en);
    pulse(en ? 4'h2 : 4'h1, 8'h00);
    chk(irq_enabled_state, en);
    pulse(4'h8, 8'h02);
    chk(state, ST_RUN);
    pulse(4'h8, HALT_OPCODE);
    chk(state, ST_IDLE);
    chk(pwr_ctrl, 5'h13);
    pm.put(4'hE);
    tick(4);
    chk(state, en ? ST_ONE_INSN : ST_RUN);
    pulse(4'h4, 8'h00);
    chk(irq_take, en);
    chk(state, ST_RUN);
    tick(1);
    chk(irq_take, 1'h0);
    pm.put(4'hF);
  endtask : t_halt
  task automatic t_idle_rst;
    pulse(4'h2, 8'h00);
    pulse(4'h8, HALT_OPCODE);
    pm.put(4'h7);
    tick(4);
    chk(state, ST_RESET);
    chk(irq_enabled_state, 1'h0);
    chk(restart_vector, RESET_VECTOR);
    pm.put(4'hF);
    tick(4);
    chk(state, ST_RUN);
  endtask : t_idle_rst
  task automatic t_pd_ram;
    pm.put(4'hB);
    tick(4);
    chk(state, ST_RUN);
    chk(pwr_ctrl.osc_run, 1'h1);
    pm.put(4'hF);
    pm.put(4'h7);
    pm.put(4'h3);
    tick(4);
    chk(state, ST_PD_RAM);
    chk({pwr_ctrl.osc_run, pwr_ctrl.core_reset, pwr_ctrl.pullup_en}, 3'h2);
    pm.put(4'hB);
    tick(4);
    chk(state, ST_PD_RAM);
    pm.put(4'h3);
    pm.put(4'h7);
    tick(4);
    chk(state, ST_RESET);
    pm.put(4'hF);
    tick(4);
    chk(state, ST_RUN);
  endtask : t_pd_ram
  task automatic t_pd_all;
    pulse(4'h2, 8'h00);
    pm.put(4'hD);
    tick(3);
    pulse(4'h4, 8'h00);
    tick(1);
    chk(state, ST_STEP);
    chk(step_wait, 1'h1);
    pm.put(4'h9);
    tick(4);
    chk(state, ST_PD_ALL);
    chk(pwr_ctrl.pullup_en, 1'h0);
    pm.put(4'hB);
    tick(4);
    chk(state, ST_PD_ALL);
    pm.put(4'h9);
    pm.put(4'hD);
    tick(4);
    chk(state, ST_STEP);
    pm.put(4'hF);
    tick(4);
    chk(state, ST_RUN);
    chk(irq_enabled_state, 1'h1);
  endtask : t_pd_all
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    chk(pwr_ctrl, 5'h1D);
    chk(state, ST_RESET);
    chk(irq_enabled_state, 1'h0);
    @(posedge ref_clk);
    rst <= 1'h0;
    tick(4);
    chk(state, ST_RUN);
    t_halt(1'h1);
    t_halt(1'h0);
    t_idle_rst;
    t_pd_ram;
    t_pd_all;
    end_sim;
  end
  initial begin
    #50us;
    n_errors++;
    end_sim;
  end
endmodule : tb_low_power_halt_control
